// ### fdcq_top.sv
// Purpose: Diskette controller command, execution and result logic
// Assumes: Register port on core_clk, drive pins asynchronous
// Notes: Disk byte slots come from a separator on core_clk
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Read-track on wrong cylinder: no error, status two wrong-cylinder bit set.
// - Read-track CRC errors show in status one and two only; host reads both.
// - Last sector number ends execution only in read-track.
// - Transfer flag stays set 12 us (8-inch) or 24 us (mini).
// - Format writes gap 5 as 40 bytes FF then 6 bytes 00.
// - Sector size is 128 shifted by code; code 0 invalid in MFM.
// - Ready may come from the pin, be tied, or index timeout.
module fdcq_top
	import fdcq_pkg::*;
#(
	parameter int STEP_MS_CYCLES = STEP_UNIT_MS * CYC_PER_MS,
	parameter int INDEX_TIMEOUT_CYCLES = INDEX_TIMEOUT_MS * CYC_PER_MS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic ready_pin,
	input wire logic index_pin,
	input wire logic track00_pin,
	input wire logic terminal_count_input,
	input wire logic [7:0] disk_byte,
	input wire logic disk_byte_valid,
	input wire logic crc_error,
	output logic step,
	output logic dir,
	output logic [7:0] wr_byte,
	output logic wr_byte_valid,
	output logic wr_gate
);
	function automatic logic [13:0] sector_bytes(input logic [2:0] code);
		sector_bytes = 14'(SIZE_BASE) << code;
	endfunction

	function automatic logic size_bad(input logic [2:0] code,
		input logic mfm);
		size_bad = (code > SIZE_MAX_CODE) || (mfm && code == 3'h0);
	endfunction

	// Pin synchronisers: ready, index, track00, terminal count
	logic [3:0] pin_in, s1_q, s2_q, s3_q, filt_q;
	assign pin_in = {terminal_count_input, track00_pin, index_pin, ready_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
				end else if (ce) begin
					s1_q[gi] <= pin_in[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						filt_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate
	logic rdy_f, idx_f, trk0_f, term_f;
	assign {term_f, trk0_f, idx_f, rdy_f} = filt_q;

	fdcq_gap_if gif ();
	fdcq_gap5 fdcq_gap5_inst (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.gif(gif)
	);

	fdcq_state_t state_q, state_d;
	logic [2:0] op_q, op_d;
	logic [7:0] cyl_cmd_q, cyl_cmd_d, cur_cyl_q, cur_cyl_d;
	logic [7:0] sector_q, sector_d, data_q, data_d;
	logic [13:0] bcnt_q, bcnt_d;
	logic pend_q, pend_d, rqm_q, rqm_d, wcyl_q, wcyl_d;
	logic crc_q, crc_d, ovr_q, ovr_d;
	logic [10:0] hold_q, hold_d, hold_cyc;
	logic [31:0] prm_q, prm_d, rdata_q, rdata_d;
	logic [23:0] st_q, st_d;
	logic [19:0] stmr_q, stmr_d;
	logic [25:0] itmr_q, itmr_d;
	logic idx_prev_q;
	logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
	logic step_q, step_d, dir_q, dir_d, gate_q, gate_d;
	logic [7:0] wrb_q, wrb_d;
	logic wrv_q, wrv_d, irq_q;
	logic ready, cmd_go, xfer, finish, is_rd, is_rt;
	logic [1:0] abn;

	assign is_rt = (op_q == OP_READ_TRACK);
	assign is_rd = (op_q == OP_READ_DATA) || is_rt;
	assign cmd_go = reg_we && reg_addr == REG_CMD && state_q == FDCQ_IDLE;
	assign xfer = state_q == FDCQ_EXEC && pend_q && reg_addr == REG_DATA &&
		(is_rd ? reg_re : reg_we);
	assign hold_cyc = prm_q[PRM_MINI] ? 11'(HOLD_5IN_CYC) : 11'(HOLD_8IN_CYC);

	always_comb begin
		// Ready source selection
		case (prm_q[PRM_RDY_LSB +: 2])
			RDY_PIN: ready = rdy_f;
			RDY_INDEX: ready = itmr_q < 26'(INDEX_TIMEOUT_CYCLES);
			default: ready = 1'b1;
		endcase
	end

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		cyl_cmd_d = cyl_cmd_q;
		cur_cyl_d = cur_cyl_q;
		sector_d = sector_q;
		data_d = data_q;
		bcnt_d = bcnt_q;
		pend_d = pend_q;
		rqm_d = rqm_q;
		wcyl_d = wcyl_q;
		crc_d = crc_q;
		ovr_d = ovr_q;
		hold_d = hold_q;
		prm_d = prm_q;
		st_d = st_q;
		stmr_d = stmr_q;
		itmr_d = (idx_f && !idx_prev_q) ? 26'h0 :
			(itmr_q == 26'h3FF_FFFF ? itmr_q : itmr_q + 26'h1);
		ien_d = ien_q;
		step_d = 1'b0;
		dir_d = dir_q;
		gate_d = gate_q;
		wrb_d = wrb_q;
		wrv_d = 1'b0;
		ev = '0;
		finish = 1'b0;
		abn = ABN_NONE;
		gif.start = 1'b0;
		if (reg_we && reg_addr == REG_PARAM)
			prm_d = reg_wdata;
		if (reg_we && reg_addr == REG_IRQ_EN)
			ien_d = reg_wdata[IRQ_W-1:0];
		case (state_q)
			FDCQ_IDLE: begin
				gate_d = 1'b0;
				if (cmd_go) begin
					op_d = reg_wdata[CMD_OP_LSB +: 3];
					cyl_cmd_d = reg_wdata[CMD_CYL_LSB +: 8];
					wcyl_d = reg_wdata[CMD_CYL_LSB +: 8] != cur_cyl_q;
					st_d = '0;
					sector_d = 8'h01;
					bcnt_d = '0;
					crc_d = 1'b0;
					ovr_d = 1'b0;
					case (reg_wdata[CMD_OP_LSB +: 3])
						OP_SEEK: begin
							state_d = FDCQ_SEEK;
							stmr_d = '0;
						end
						OP_READ_DATA, OP_WRITE_DATA, OP_READ_TRACK,
						OP_FORMAT: begin
							if (!ready) begin
								st_d[ST0_ABN_LSB +: 2] = ABN_FAIL;
								st_d[ST0_NOT_READY] = 1'b1;
								ev[IRQ_DONE] = 1'b1;
							end else if (size_bad(prm_q[PRM_SIZE_LSB +: 3],
								prm_q[PRM_MFM])) begin
								st_d[ST0_ABN_LSB +: 2] = ABN_INVALID;
								ev[IRQ_DONE] = 1'b1;
							end else if (reg_wdata[CMD_OP_LSB +: 3] ==
								OP_FORMAT) begin
								state_d = FDCQ_GAP5;
								gif.start = 1'b1;
								gate_d = 1'b1;
							end else begin
								state_d = FDCQ_EXEC;
								gate_d = reg_wdata[CMD_OP_LSB +: 3] ==
									OP_WRITE_DATA;
							end
						end
						default: begin
							// Scan and unknown codes are refused
							st_d[ST0_ABN_LSB +: 2] = ABN_INVALID;
							ev[IRQ_DONE] = 1'b1;
						end
					endcase
				end
			end
			FDCQ_SEEK: begin
				if (cur_cyl_q == cyl_cmd_q ||
					(cyl_cmd_q == 8'h00 && trk0_f)) begin
					cur_cyl_d = cyl_cmd_q;
					st_d[ST0_SEEK_END] = 1'b1;
					ev[IRQ_SEEK] = 1'b1;
					state_d = FDCQ_IDLE;
				end else if (stmr_q == '0) begin
					// Step period from programmed rate
					step_d = 1'b1;
					dir_d = cyl_cmd_q > cur_cyl_q;
					cur_cyl_d = (cyl_cmd_q > cur_cyl_q) ?
						cur_cyl_q + 8'h01 : cur_cyl_q - 8'h01;
					stmr_d = 20'((32'(prm_q[PRM_RATE_LSB +: 4]) + 32'd1) *
						32'(STEP_MS_CYCLES) - 32'd1);
				end else begin
					stmr_d = stmr_q - 20'h1;
				end
			end
			FDCQ_EXEC: begin
				if (hold_q != '0) begin
					hold_d = hold_q - 11'h1;
					if (hold_q == 11'h1 && !pend_q)
						rqm_d = 1'b0;
				end
				if (xfer) begin
					pend_d = 1'b0;
					hold_d = hold_cyc;
					if (!is_rd) begin
						wrb_d = reg_wdata[7:0];
						wrv_d = 1'b1;
					end
					if (bcnt_q == sector_bytes(prm_q[PRM_SIZE_LSB +: 3]) -
						14'h1) begin
						bcnt_d = '0;
						sector_d = sector_q + 8'h01;
						// Last sector ends read-track only
						if (is_rt && sector_q == prm_q[PRM_LAST_LSB +: 8])
							finish = 1'b1;
					end else begin
						bcnt_d = bcnt_q + 14'h1;
					end
				end
				if (disk_byte_valid) begin
					if (pend_q && !xfer) begin
						ovr_d = 1'b1;
						finish = 1'b1;
					end else begin
						pend_d = 1'b1;
						rqm_d = 1'b1;
						ev[IRQ_DATA] = 1'b1;
						if (is_rd)
							data_d = disk_byte;
						crc_d = crc_q || crc_error;
					end
				end
				if (term_f)
					finish = 1'b1;
			end
			FDCQ_GAP5: begin
				if (gif.byte_stb) begin
					wrb_d = gif.byte_val;
					wrv_d = 1'b1;
				end
				if (gif.done)
					finish = 1'b1;
			end
			default: state_d = FDCQ_IDLE;
		endcase
		if (finish) begin
			// Read-track keeps ST0 clean for cylinder and CRC
			if (ovr_d || (!is_rt && (crc_d || wcyl_q)))
				abn = ABN_FAIL;
			st_d[ST0_ABN_LSB +: 2] = abn;
			st_d[8 + RS1_DATA_ERR] = crc_d && is_rd;
			st_d[8 + RS1_OVERRUN] = ovr_d;
			st_d[16 + RS2_DATA_CRC] = crc_d && is_rd;
			st_d[16 + RS2_WRONG_CYL] = wcyl_q && is_rd;
			ev[IRQ_DONE] = 1'b1;
			state_d = FDCQ_IDLE;
			pend_d = 1'b0;
			rqm_d = 1'b0;
			hold_d = '0;
			// Gate covers a last byte, drops in idle
			gate_d = wrv_d;
		end
		// Event set wins over software clear
		ist_d = ist_q;
		if (reg_we && reg_addr == REG_IRQ_CLR)
			ist_d = ist_q & ~reg_wdata[IRQ_W-1:0];
		ist_d = ist_d | ev;
		rdata_d = '0;
		if (reg_re) begin
			case (reg_addr)
				REG_PARAM: rdata_d = prm_q;
				REG_MAIN: begin
					rdata_d[MSR_XFER_REQ] = state_q == FDCQ_IDLE || rqm_q;
					rdata_d[MSR_DIO] = state_q == FDCQ_EXEC && is_rd;
					rdata_d[MSR_EXEC] = state_q == FDCQ_EXEC;
					rdata_d[MSR_BUSY] = state_q != FDCQ_IDLE;
				end
				REG_DATA: rdata_d = {24'h0, data_q};
				REG_RESULT: rdata_d = {cur_cyl_q, st_q};
				REG_IRQ_STAT: rdata_d = 32'(ist_q);
				REG_IRQ_EN: rdata_d = 32'(ien_q);
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= FDCQ_IDLE;
			op_q <= 3'h0;
			cyl_cmd_q <= 8'h00;
			cur_cyl_q <= 8'h00;
			sector_q <= 8'h00;
			data_q <= 8'h00;
			bcnt_q <= '0;
			pend_q <= 1'b0;
			rqm_q <= 1'b0;
			wcyl_q <= 1'b0;
			crc_q <= 1'b0;
			ovr_q <= 1'b0;
			hold_q <= '0;
			prm_q <= PRM_RESET;
			st_q <= '0;
			stmr_q <= '0;
			itmr_q <= '0;
			idx_prev_q <= 1'b0;
			ist_q <= '0;
			ien_q <= '0;
			step_q <= 1'b0;
			dir_q <= 1'b0;
			gate_q <= 1'b0;
			wrb_q <= 8'h00;
			wrv_q <= 1'b0;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			op_q <= op_d;
			cyl_cmd_q <= cyl_cmd_d;
			cur_cyl_q <= cur_cyl_d;
			sector_q <= sector_d;
			data_q <= data_d;
			bcnt_q <= bcnt_d;
			pend_q <= pend_d;
			rqm_q <= rqm_d;
			wcyl_q <= wcyl_d;
			crc_q <= crc_d;
			ovr_q <= ovr_d;
			hold_q <= hold_d;
			prm_q <= prm_d;
			st_q <= st_d;
			stmr_q <= stmr_d;
			itmr_q <= itmr_d;
			idx_prev_q <= idx_f;
			ist_q <= ist_d;
			ien_q <= ien_d;
			step_q <= step_d;
			dir_q <= dir_d;
			gate_q <= gate_d;
			wrb_q <= wrb_d;
			wrv_q <= wrv_d;
			irq_q <= |(ist_q & ien_q);
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign step = step_q;
	assign dir = dir_q;
	assign wr_byte = wrb_q;
	assign wr_byte_valid = wrv_q;
	assign wr_gate = gate_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_rtrack_wrong_cyl: assert property (
		(ce && finish && is_rt && wcyl_q && !ovr_d) |=>
		(st_q[16 + RS2_WRONG_CYL] && st_q[ST0_ABN_LSB +: 2] == ABN_NONE))
		else $error("read-track wrong cylinder misreported");
	chk_rtrack_crc_quiet: assert property (
		(ce && finish && is_rt && crc_d && !ovr_d) |=>
		(st_q[8 + RS1_DATA_ERR] && st_q[ST0_ABN_LSB +: 2] == ABN_NONE))
		else $error("read-track crc status wrong");
	chk_term_ends_exec: assert property (
		(ce && state_q == FDCQ_EXEC && term_f) |=>
		(state_q == FDCQ_IDLE && ist_q[IRQ_DONE]))
		else $error("terminal count did not end execution");
	chk_last_sector_rt: assert property (
		(ce && state_q == FDCQ_EXEC && !is_rt && !term_f &&
		!(disk_byte_valid && pend_q && !xfer)) |=> state_q == FDCQ_EXEC)
		else $error("execution ended without terminal count");
	chk_rqm_hold: assert property (
		(ce && xfer && !finish) |=>
		(rqm_q && hold_q == hold_cyc) ##1 (!ce || rqm_q))
		else $error("transfer flag hold wrong");
	chk_size_invalid: assert property (
		(cmd_go && ce && ready && prm_q[PRM_MFM] &&
		prm_q[PRM_SIZE_LSB +: 3] == 3'h0 &&
		reg_wdata[CMD_OP_LSB +: 3] == OP_READ_DATA) |=>
		(state_q == FDCQ_IDLE && st_q[ST0_ABN_LSB +: 2] == ABN_INVALID))
		else $error("size code 0 in MFM accepted");
	chk_ready_tied: assert property (
		(cmd_go && ce && prm_q[PRM_RDY_LSB +: 2] == RDY_TIED) |=>
		!st_q[ST0_NOT_READY])
		else $error("tied ready reported not ready");
endmodule
`default_nettype wire

// ### fdcq_pkg.sv
// Purpose: Shared constants for the diskette command interpreter
// Assumes: 50 MHz core clock, 32-bit register port
// Notes: Register offsets are byte addresses of aligned words
package fdcq_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_PARAM = 8'h04;
	localparam logic [7:0] REG_MAIN = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0C;
	localparam logic [7:0] REG_RESULT = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] REG_IRQ_EN = 8'h1C;
	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_CYL_LSB = 8;
	localparam logic [2:0] OP_READ_DATA = 3'h1;
	localparam logic [2:0] OP_WRITE_DATA = 3'h2;
	localparam logic [2:0] OP_READ_TRACK = 3'h3;
	localparam logic [2:0] OP_FORMAT = 3'h4;
	localparam logic [2:0] OP_SEEK = 3'h5;
	// Parameter register fields
	localparam int PRM_LAST_LSB = 0;
	localparam int PRM_GAP_LSB = 8;
	localparam int PRM_SIZE_LSB = 16;
	localparam int PRM_MFM = 24;
	localparam int PRM_MINI = 25;
	localparam int PRM_RDY_LSB = 26;
	localparam int PRM_RATE_LSB = 28;
	localparam logic [31:0] PRM_RESET = 32'h0000_0000;
	localparam logic [1:0] RDY_PIN = 2'h0;
	localparam logic [1:0] RDY_INDEX = 2'h1;
	localparam logic [1:0] RDY_TIED = 2'h2;
	// Main status bits
	localparam int MSR_XFER_REQ = 7;
	localparam int MSR_DIO = 6;
	localparam int MSR_EXEC = 5;
	localparam int MSR_BUSY = 4;
	// Result status bits
	localparam int ST0_ABN_LSB = 6;
	localparam int ST0_SEEK_END = 5;
	localparam int ST0_NOT_READY = 3;
	localparam logic [1:0] ABN_NONE = 2'h0;
	localparam logic [1:0] ABN_FAIL = 2'h1;
	localparam logic [1:0] ABN_INVALID = 2'h2;
	localparam int RS1_DATA_ERR = 5;
	localparam int RS1_OVERRUN = 4;
	localparam int RS2_DATA_CRC = 5;
	localparam int RS2_WRONG_CYL = 4;
	// Interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_DATA = 1;
	localparam int IRQ_SEEK = 2;
	// Sector size
	localparam int SIZE_BASE = 128;
	localparam logic [2:0] SIZE_MAX_CODE = 3'h6;
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int HOLD_8IN_US = 12;
	localparam int HOLD_5IN_US = 24;
	localparam int HOLD_8IN_CYC = HOLD_8IN_US * CLK_MHZ;
	localparam int HOLD_5IN_CYC = HOLD_5IN_US * CLK_MHZ;
	localparam int STEP_UNIT_MS = 1;
	localparam int INDEX_TIMEOUT_MS = 400;
	// Fixed gap 5
	localparam int GAP5_FF_BYTES = 40;
	localparam int GAP5_SYNC_BYTES = 6;
	localparam logic [7:0] GAP5_FILL = 8'hFF;
	localparam logic [7:0] GAP5_SYNC = 8'h00;
	typedef enum logic [2:0] {
		FDCQ_IDLE, FDCQ_SEEK, FDCQ_EXEC, FDCQ_GAP5
	} fdcq_state_t;
endpackage

// ### fdcq_gap_if.sv
// Purpose: Carrier between command logic and gap generator
// Assumes: One clock domain
// Notes: Start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface fdcq_gap_if;
	logic start;
	logic busy;
	logic done;
	logic [7:0] byte_val;
	logic byte_stb;
	modport gen (input start, output busy, done, byte_val, byte_stb);
	modport ctl (output start, input busy, done, byte_val, byte_stb);
endinterface
`default_nettype wire

// ### fdcq_gap5.sv
// Purpose: Emits the fixed gap 5 byte pattern during format
// Assumes: One byte per enabled cycle
// Notes: Done pulses in the same cycle as the last sync byte strobe
`timescale 1ns/1ps
`default_nettype none
module fdcq_gap5
	import fdcq_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	fdcq_gap_if.gen gif
);
	localparam int TOTAL = GAP5_FF_BYTES + GAP5_SYNC_BYTES;
	logic [5:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d, stb_q, stb_d;
	logic [7:0] byte_q, byte_d;
	logic [6:0] seen_q;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		stb_d = 1'b0;
		byte_d = byte_q;
		if (gif.start && !busy_q) begin
			busy_d = 1'b1;
			cnt_d = 6'h00;
		end else if (busy_q) begin
			stb_d = 1'b1;
			// Fill bytes first, then sync bytes
			byte_d = (cnt_q < 6'(GAP5_FF_BYTES)) ? GAP5_FILL : GAP5_SYNC;
			cnt_d = cnt_q + 6'h01;
			if (cnt_q == 6'(TOTAL - 1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 6'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			stb_q <= 1'b0;
			byte_q <= 8'h00;
		end else if (ce) begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
			stb_q <= stb_d;
			byte_q <= byte_d;
		end
	end

	assign gif.busy = busy_q;
	assign gif.done = done_q;
	assign gif.byte_val = byte_q;
	assign gif.byte_stb = stb_q;

	// Helper: bytes emitted since start
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seen_q <= 7'h00;
		end else if (ce) begin
			if (gif.start && !busy_q)
				seen_q <= 7'h00;
			else if (stb_d)
				seen_q <= seen_q + 7'h01;
		end
	end

	chk_gap5_count: assert property (@(posedge core_clk) disable iff (rst)
		(ce && done_d) |-> (seen_q == 7'(TOTAL - 1)))
		else $error("gap 5 length wrong");
	chk_gap5_fill: assert property (@(posedge core_clk) disable iff (rst)
		(stb_q && seen_q <= 7'(GAP5_FF_BYTES)) |-> (byte_q == GAP5_FILL))
		else $error("gap 5 fill byte wrong");
endmodule
`default_nettype wire

// ### fdcq_drive_model.sv
// Purpose: Drive-side model for the diskette command interpreter
// Assumes: Byte slots are requested by the bench
// Notes: Cylinder follows step and dir; bytes count up from 0
`timescale 1ns/1ps
`default_nettype none
module fdcq_drive_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic step,
	input wire logic dir,
	input wire logic slot_go,
	input wire logic crc_inj,
	input wire logic rdy_en,
	input wire logic idx_en,
	output logic ready_pin,
	output logic index_pin,
	output logic track00_pin,
	output logic [7:0] disk_byte,
	output logic disk_byte_valid,
	output logic crc_error
);
	logic [7:0] cyl_q;
	logic [7:0] cnt_q;
	logic [5:0] idx_q;
	// Ready from the pin, or index pulses for a timeout circuit
	assign ready_pin = rdy_en;
	assign index_pin = idx_en && (idx_q < 6'h02);
	assign track00_pin = (cyl_q == 8'h00);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cyl_q <= 8'h00;
			cnt_q <= 8'h00;
			idx_q <= 6'h00;
			disk_byte <= 8'h00;
			disk_byte_valid <= 1'b0;
			crc_error <= 1'b0;
		end else begin
			idx_q <= (idx_q == 6'h1D) ? 6'h00 : idx_q + 6'h01;
			if (step) begin
				if (dir)
					cyl_q <= cyl_q + 8'h01;
				else if (cyl_q != 8'h00)
					cyl_q <= cyl_q - 8'h01;
			end
			disk_byte_valid <= slot_go;
			crc_error <= slot_go && crc_inj;
			// Outside a slot the byte lines toggle every cycle
			if (slot_go) begin
				disk_byte <= cnt_q;
				cnt_q <= cnt_q + 8'h01;
			end else begin
				disk_byte <= ~disk_byte;
			end
		end
	end
endmodule
`default_nettype wire

// ### fdcq_top_bench.sv
// Purpose: Self-checking bench for the diskette command interpreter
// Assumes: Short step and index-timeout counts
// Notes: Bench plays the host on the register port
`timescale 1ns/1ps
`default_nettype none
module fdcq_top_bench import fdcq_pkg::*;;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic term_cnt = 1'b0;
	logic slot_go = 1'b0;
	logic crc_inj = 1'b0;
	logic rdy_en = 1'b1;
	logic idx_en = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] d;
	logic irq, ready_pin, index_pin, track00_pin, step, dir;
	logic disk_byte_valid, crc_error, wr_byte_valid, wr_gate, dir_seen;
	logic [7:0] disk_byte, wr_byte;
	logic [7:0] nb = 8'h00;
	logic [7:0] fq[$];
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int nstep = 0;
	int gate_bad = 0;
	int t0 = 0;
	int t1 = 0;
	int k;
	fdcq_top #(.STEP_MS_CYCLES(10), .INDEX_TIMEOUT_CYCLES(50)) fdcq_top_inst (
		.core_clk(core_clk), .rst(rst), .ce(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
		.ready_pin(ready_pin), .index_pin(index_pin),
		.track00_pin(track00_pin), .terminal_count_input(term_cnt),
		.disk_byte(disk_byte), .disk_byte_valid(disk_byte_valid),
		.crc_error(crc_error), .step(step), .dir(dir),
		.wr_byte(wr_byte), .wr_byte_valid(wr_byte_valid),
		.wr_gate(wr_gate)
	);
	fdcq_drive_model fdcq_drive_model_inst (
		.core_clk(core_clk), .rst(rst), .step(step), .dir(dir),
		.slot_go(slot_go), .crc_inj(crc_inj), .rdy_en(rdy_en),
		.idx_en(idx_en), .ready_pin(ready_pin), .index_pin(index_pin),
		.track00_pin(track00_pin), .disk_byte(disk_byte),
		.disk_byte_valid(disk_byte_valid), .crc_error(crc_error)
	);
	always #10 core_clk = ~core_clk;
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Step timing, format bytes and the run limit
	always @(posedge core_clk) begin
		cyc++;
		if (step === 1'b1) begin
			nstep++;
			t0 = t1;
			t1 = cyc;
			dir_seen = dir;
		end
		if (wr_byte_valid === 1'b1) begin
			fq.push_back(wr_byte);
			if (wr_gate !== 1'b1) gate_bad++;
		end
		if (cyc == 40000) begin
			miscompares++;
			close_out();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_we <= 1'b1;
		@(posedge core_clk);
		reg_we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge core_clk);
		reg_re <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task wait_done();
		int j;
		logic [31:0] s;
		s = 32'h0;
		for (j = 0; j < 500 && s[IRQ_DONE] !== 1'b1; j++)
			rd(REG_IRQ_STAT, s);
		chk({31'h0, s[IRQ_DONE]}, 32'h1);
		wr(REG_IRQ_CLR, 32'h7);
	endtask
	// One disk byte slot, then the host takes the byte
	task xfer(input logic crc);
		@(posedge core_clk);
		slot_go <= 1'b1;
		crc_inj <= crc;
		@(posedge core_clk);
		slot_go <= 1'b0;
		crc_inj <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd(REG_DATA, d);
		chk(d & 32'hFF, {24'h0, nb});
		nb = nb + 8'h01;
	endtask
	task rd_data(input logic mini);
		int j;
		// Gap 07 for read and write commands
		wr(REG_PARAM, 32'h0800_0701 | {6'h0, mini, 25'h0});
		wr(REG_CMD, 32'h0000_0201);
		for (j = 0; j < 130; j++) xfer(1'b0);
		rd(REG_IRQ_STAT, d);
		chk(d & 32'h1, 32'h0);
		repeat (mini ? 1100 : 500) @(posedge core_clk);
		rd(REG_MAIN, d);
		chk(d & 32'h80, 32'h80);
		repeat (200) @(posedge core_clk);
		rd(REG_MAIN, d);
		chk(d & 32'h80, 32'h0);
		@(posedge core_clk);
		term_cnt <= 1'b1;
		wait_done();
		@(posedge core_clk);
		term_cnt <= 1'b0;
		rd(REG_RESULT, d);
		chk(d & 32'h0010_0000, 32'h0);
		$display("read data test done");
	endtask
	task run_cmd(input logic [31:0] prm, input logic [31:0] cmd,
		input logic rdy, input logic idx, input logic [1:0] abn);
		@(posedge core_clk);
		rdy_en <= rdy;
		idx_en <= idx;
		repeat (100) @(posedge core_clk);
		wr(REG_PARAM, prm);
		wr(REG_CMD, cmd);
		wait_done();
		rd(REG_RESULT, d);
		chk({30'h0, d[7:6]}, {30'h0, abn});
		chk({31'h0, d[ST0_NOT_READY]}, {31'h0, abn == 2'h1});
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_PARAM, d);
		chk(d, PRM_RESET);
		rd(REG_IRQ_STAT, d);
		chk(d, 32'h0);
		rd(8'h20, d);
		chk(d, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("reset test done");
		// Step rate 2 ms against a 1 ms drive
		wr(REG_IRQ_EN, 32'h4);
		wr(REG_PARAM, 32'h1800_0000);
		wr(REG_CMD, 32'h0000_0205);
		for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge core_clk);
		chk(nstep, 2);
		chk(t1 - t0, 20);
		chk({31'h0, dir_seen}, 32'h1);
		rd(REG_RESULT, d);
		chk(d & 32'hFF00_00E0, 32'h0200_0020);
		wr(REG_IRQ_EN, 32'h0);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(REG_IRQ_EN, 32'h4);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		wr(REG_IRQ_CLR, 32'h7);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		$display("seek test done");
		// Read-track on cylinder 5 while the head sits on 2
		wr(REG_PARAM, 32'h0801_0701);
		wr(REG_CMD, 32'h0000_0503);
		for (k = 0; k < 256; k++) begin
			if (k == 255) begin
				rd(REG_IRQ_STAT, d);
				chk(d & 32'h1, 32'h0);
			end
			xfer(k == 10);
		end
		wait_done();
		rd(REG_RESULT, d);
		chk(d & 32'hC0, 32'h0);
		chk(d & 32'h0010_0000, 32'h0010_0000);
		chk(d & 32'h0020_2000, 32'h0020_2000);
		$display("read track test done");
		rd_data(1'b0);
		rd_data(1'b1);
		// Format gap 1B
		wr(REG_PARAM, 32'h0800_1B00);
		fq.delete();
		wr(REG_CMD, 32'h0000_0204);
		wait_done();
		chk(fq.size(), 46);
		chk(gate_bad, 0);
		for (k = 0; k < 46; k++)
			chk({24'h0, fq[k]}, (k < 40) ? 32'hFF : 32'h0);
		$display("format test done");
		run_cmd(32'h0900_0001, 32'h0000_0201, 1, 1, 2'h2);
		run_cmd(32'h0807_0001, 32'h0000_0201, 1, 1, 2'h2);
		run_cmd(32'h0800_0001, 32'h0000_0207, 1, 1, 2'h2);
		// Ready source checks use format, which ends by itself
		run_cmd(32'h0000_0001, 32'h0000_0204, 0, 1, 2'h1);
		run_cmd(32'h0400_0001, 32'h0000_0204, 0, 1, 2'h0);
		run_cmd(32'h0400_0001, 32'h0000_0204, 1, 0, 2'h1);
		run_cmd(32'h0C00_0001, 32'h0000_0204, 0, 1, 2'h0);
		$display("refusal test done");
		// Mini write, settle 1.3 ms (13 cycles here), step back to 0
		fq.delete();
		wr(REG_PARAM, 32'h0A00_0701);
		wr(REG_CMD, 32'h0000_0202);
		@(posedge core_clk);
		slot_go <= 1'b1;
		@(posedge core_clk);
		slot_go <= 1'b0;
		repeat (3) @(posedge core_clk);
		wr(REG_DATA, 32'h0000_005A);
		repeat (2) @(posedge core_clk);
		chk(fq.size(), 1);
		chk({24'h0, fq[0]}, 32'h5A);
		rd(REG_MAIN, d);
		chk(d & 32'hF0, 32'hB0);
		@(posedge core_clk);
		term_cnt <= 1'b1;
		wait_done();
		@(posedge core_clk);
		term_cnt <= 1'b0;
		chk({31'h0, wr_gate}, 32'h0);
		chk(gate_bad, 0);
		repeat (13) @(posedge core_clk);
		wr(REG_CMD, 32'h0000_0005);
		repeat (40) @(posedge core_clk);
		chk(nstep, 4);
		chk({31'h0, dir_seen}, 32'h0);
		rd(REG_RESULT, d);
		chk(d & 32'hFF00_00E0, 32'h0000_0020);
		$display("write test done");
		close_out();
	end
endmodule
`default_nettype wire
